// file: src/rx_sys_port_pkg.sv
`default_nettype none
package rx_sys_port_pkg;

  // Link count and field widths
  localparam int LINKS  = 2;
  localparam int BYTE_W = 8;
  localparam int SIG_W  = 4;
  localparam int BIT_W  = 3;

  // Port operating modes
  typedef enum logic [1:0]
  {
    MODE_MASTER = 2'b00,
    MODE_SLAVE  = 2'b01,
    MODE_MUXED  = 2'b10
  } port_mode_t;

  // One channel: payload byte and its signaling nibble
  typedef struct packed
  {
    logic [BYTE_W-1:0] payload;
    logic [SIG_W-1:0]  sig;
  } chan_word_t;

  typedef chan_word_t [LINKS-1:0] chan_pair_t;

  // Word held in the multiplexed-path FIFO
  typedef struct packed
  {
    logic       link2;
    chan_word_t word;
  } mux_word_t;

  localparam int MUX_WORD_W = $bits(mux_word_t);
  localparam int MUX_FIFO_DEPTH = 8;

  // Fill values and stream layout
  localparam logic [BYTE_W-1:0] IDLE_PAYLOAD = 8'hFF;
  localparam logic [SIG_W-1:0]  IDLE_SIG     = 4'hF;
  localparam logic [SIG_W-1:0]  SIG_UPPER    = 4'h0;
  localparam logic              F_BIT_VALUE  = 1'b0;
  localparam logic              F_SIG_VALUE  = 1'b0;

  // Frame bit counter: first and last bit index of each frame
  localparam int FRAME_W = 9;
  localparam logic [FRAME_W-1:0] FRAME_FIRST   = 9'h000;
  localparam logic [FRAME_W-1:0] T1_FRAME_LAST = 9'h0C0;
  localparam logic [FRAME_W-1:0] E1_FRAME_LAST = 9'h0FF;
  localparam logic [BIT_W-1:0]   BIT_FIRST     = 3'h0;

  // Master clock synthesis from the core clock
  localparam longint CLK_HZ    = 100_000_000;
  localparam longint T1_CLK_HZ = 1_544_000;
  localparam longint E1_CLK_HZ = 2_048_000;
  localparam int     NCO_W     = 24;
  localparam logic [NCO_W-1:0] T1_NCO_INC = NCO_W'((T1_CLK_HZ << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] E1_NCO_INC = NCO_W'((E1_CLK_HZ << NCO_W) / CLK_HZ);

endpackage : rx_sys_port_pkg
`default_nettype wire

// file: src/rx_sys_port.sv
`timescale 1ns/1ns
`default_nettype none

module rx_cdc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_rst,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic             rd_clk,
  input  wire logic             rd_rst,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] peer_s1;
    logic [AW:0] peer_s2;
  } side_t;

  side_t            w;
  side_t            next_w;
  side_t            r;
  side_t            next_r;
  logic [WIDTH-1:0] mem [DEPTH];

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // Full when write pointer is one lap ahead
  assign wr_ready = (w.gray != {~w.peer_s2[AW:AW-1], w.peer_s2[AW-2:0]});
  assign rd_valid = (r.gray != r.peer_s2);
  assign rd_data  = mem[r.bin[AW-1:0]];

  always_comb
  begin
    next_w         = w;
    next_w.peer_s1 = r.gray;
    next_w.peer_s2 = w.peer_s1;
    if (wr_valid && wr_ready)
    begin
      next_w.bin  = w.bin + 1'b1;
      next_w.gray = to_gray(next_w.bin);
    end
    next_r         = r;
    next_r.peer_s1 = w.gray;
    next_r.peer_s2 = r.peer_s1;
    if (rd_valid && rd_ready)
    begin
      next_r.bin  = r.bin + 1'b1;
      next_r.gray = to_gray(next_r.bin);
    end
  end

  always_ff @(posedge wr_clk or posedge wr_rst)
  begin
    if (wr_rst)
      w <= '0;
    else
      w <= next_w;
  end

  always_ff @(posedge wr_clk)
  begin
    if (wr_valid && wr_ready)
      mem[w.bin[AW-1:0]] <= wr_data;
  end

  always_ff @(posedge rd_clk or posedge rd_rst)
  begin
    if (rd_rst)
      r <= '0;
    else
      r <= next_r;
  end
endmodule : rx_cdc_fifo

module rx_link_serializer (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       tick,
  input  wire logic                       frame_sync,
  input  wire logic                       e1_mode,
  input  wire rx_sys_port_pkg::chan_word_t word,
  input  wire logic                       word_valid,
  output logic                            word_ready,
  output logic                            payload_out,
  output logic                            sig_out,
  output logic                            frame_mark
);
  typedef struct packed
  {
    logic [rx_sys_port_pkg::BYTE_W-1:0]  payload_sh;
    logic [rx_sys_port_pkg::BYTE_W-1:0]  sig_sh;
    logic [rx_sys_port_pkg::BIT_W-1:0]   bit_idx;
    logic [rx_sys_port_pkg::FRAME_W-1:0] frame_bit;
    logic                                payload_q;
    logic                                sig_q;
    logic                                mark_q;
  } ser_state_t;

  ser_state_t                          s;
  ser_state_t                          next_s;
  logic [rx_sys_port_pkg::FRAME_W-1:0] pos;
  logic [rx_sys_port_pkg::FRAME_W-1:0] last;
  logic                                f_slot;
  logic                                load;
  logic [rx_sys_port_pkg::BYTE_W-1:0]  pay;
  logic [rx_sys_port_pkg::BYTE_W-1:0]  sig;

  assign payload_out = s.payload_q;
  assign sig_out     = s.sig_q;
  assign frame_mark  = s.mark_q;
  assign word_ready  = tick && load;

  always_comb
  begin
    next_s = s;
    pos    = frame_sync ? rx_sys_port_pkg::FRAME_FIRST : s.frame_bit;
    last   = e1_mode ? rx_sys_port_pkg::E1_FRAME_LAST : rx_sys_port_pkg::T1_FRAME_LAST;
    f_slot = !e1_mode && (pos == rx_sys_port_pkg::FRAME_FIRST);
    load   = !f_slot && (frame_sync || (s.bit_idx == rx_sys_port_pkg::BIT_FIRST));
    pay    = s.payload_sh;
    sig    = s.sig_sh;
    if (load)
    begin
      pay = word_valid ? word.payload : rx_sys_port_pkg::IDLE_PAYLOAD;
      // Nibble in b5..b8, sent with its payload byte
      sig = {rx_sys_port_pkg::SIG_UPPER,
             word_valid ? word.sig : rx_sys_port_pkg::IDLE_SIG};
    end
    // Outputs move only on the selected clock's edge
    if (tick)
    begin
      next_s.mark_q = (pos == rx_sys_port_pkg::FRAME_FIRST);
      if (f_slot)
      begin
        next_s.payload_q = rx_sys_port_pkg::F_BIT_VALUE;
        next_s.sig_q     = rx_sys_port_pkg::F_SIG_VALUE;
        next_s.bit_idx   = rx_sys_port_pkg::BIT_FIRST;
      end
      else
      begin
        next_s.payload_q  = pay[rx_sys_port_pkg::BYTE_W-1];
        next_s.sig_q      = sig[rx_sys_port_pkg::BYTE_W-1];
        next_s.payload_sh = {pay[rx_sys_port_pkg::BYTE_W-2:0], 1'b0};
        next_s.sig_sh     = {sig[rx_sys_port_pkg::BYTE_W-2:0], 1'b0};
        next_s.bit_idx    = (load ? rx_sys_port_pkg::BIT_FIRST : s.bit_idx) + 1'b1;
      end
      next_s.frame_bit = (pos == last) ? rx_sys_port_pkg::FRAME_FIRST : pos + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : rx_link_serializer

module rx_sys_port (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire rx_sys_port_pkg::port_mode_t link_mode,
  input  wire logic                        rx_shared_slave_clock_sel,
  input  wire logic [1:0]                  e1_mode,
  input  wire rx_sys_port_pkg::chan_pair_t link_word,
  input  wire logic [1:0]                  link_word_valid,
  output logic      [1:0]                  link_word_ready,
  input  wire logic [1:0]                  rx_sys_clock_in,
  output logic      [1:0]                  rx_sys_clock_out,
  output logic      [1:0]                  rx_sys_clock_oe_n,
  input  wire logic [1:0]                  rx_sys_frame_pulse_in,
  output logic      [1:0]                  rx_sys_frame_pulse_out,
  output logic      [1:0]                  rx_sys_frame_pulse_oe_n,
  output logic      [1:0]                  rx_sys_payload_out,
  output logic      [1:0]                  rx_sys_signaling_out,
  input  wire logic                        rx_muxed_clock,
  input  wire logic                        rx_muxed_frame_pulse,
  output logic                             rx_muxed_payload_out,
  output logic                             rx_muxed_signaling_out
);
  localparam int NMSB = rx_sys_port_pkg::NCO_W - 1;

  typedef struct packed
  {
    logic [1:0]                              clk_s1;
    logic [1:0]                              clk_s2;
    logic [1:0]                              clk_q;
    logic [1:0]                              fp_s1;
    logic [1:0]                              fp_s2;
    logic [1:0][rx_sys_port_pkg::NCO_W-1:0] nco;
    logic [1:0]                              nco_q;
    logic                                    turn;
    logic                                    oe_n;
  } core_state_t;

  typedef struct packed
  {
    logic fp_s1;
    logic fp_s2;
  } mux_state_t;

  core_state_t                 s;
  core_state_t                 next_s;
  mux_state_t                  m;
  mux_state_t                  next_m;
  logic [1:0]                  tick;
  logic [1:0]                  fsync;
  logic [1:0]                  ser_ready;
  logic [1:0]                  edge_in;
  logic [1:0]                  edge_m;
  logic [1:0]                  mark;
  logic                        master;
  logic                        muxed;
  rx_sys_port_pkg::mux_word_t  wr_word;
  rx_sys_port_pkg::mux_word_t  rd_word;
  logic                        fifo_wr_valid;
  logic                        fifo_wr_ready;
  logic                        fifo_rd_valid;
  logic                        fifo_rd_ready;

  assign master = (link_mode == rx_sys_port_pkg::MODE_MASTER);
  assign muxed  = (link_mode == rx_sys_port_pkg::MODE_MUXED);

  always_comb
  begin
    next_s        = s;
    next_s.clk_s1 = rx_sys_clock_in;
    next_s.clk_s2 = s.clk_s1;
    next_s.clk_q  = s.clk_s2;
    next_s.fp_s1  = rx_sys_frame_pulse_in;
    next_s.fp_s2  = s.fp_s1;
    next_s.oe_n   = !master;
    for (int i = 0; i < rx_sys_port_pkg::LINKS; i++)
    begin
      // Rate follows the link's line standard
      next_s.nco[i] = s.nco[i] + (e1_mode[i] ? rx_sys_port_pkg::E1_NCO_INC
                                             : rx_sys_port_pkg::T1_NCO_INC);
      next_s.nco_q[i] = s.nco[i][NMSB];
      edge_m[i]  = s.nco[i][NMSB] && !s.nco_q[i];
      edge_in[i] = s.clk_s2[i] && !s.clk_q[i];
    end
    // Each link on its own clock, or link two on link one's
    tick[0] = !muxed && (master ? edge_m[0] : edge_in[0]);
    tick[1] = !muxed && (master ? edge_m[1]
                                : (rx_shared_slave_clock_sel ? edge_in[0]
                                                             : edge_in[1]));
    fsync[0] = !master && s.fp_s2[0];
    fsync[1] = !master && s.fp_s2[1];
    // Alternate the links into the multiplexed path
    wr_word.link2 = s.turn;
    wr_word.word  = link_word[s.turn];
    fifo_wr_valid = muxed && link_word_valid[s.turn];
    for (int i = 0; i < rx_sys_port_pkg::LINKS; i++)
      link_word_ready[i] = muxed ? (s.turn == 1'(i)) && fifo_wr_ready : ser_ready[i];
    if (fifo_wr_valid && fifo_wr_ready)
      next_s.turn = !s.turn;
    if (!muxed)
      next_s.turn = 1'b0;
    next_m       = m;
    next_m.fp_s1 = rx_muxed_frame_pulse;
    next_m.fp_s2 = m.fp_s1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  always_ff @(posedge rx_muxed_clock or posedge rst)
  begin
    if (rst)
      m <= '0;
    else
      m <= next_m;
  end

  for (genvar g = 0; g < rx_sys_port_pkg::LINKS; g++)
  begin : g_link
    rx_link_serializer u_ser (
      .clk         (clk),
      .rst         (rst),
      .tick        (tick[g]),
      .frame_sync  (fsync[g]),
      .e1_mode     (e1_mode[g]),
      .word        (link_word[g]),
      .word_valid  (link_word_valid[g] && !muxed),
      .word_ready  (ser_ready[g]),
      .payload_out (rx_sys_payload_out[g]),
      .sig_out     (rx_sys_signaling_out[g]),
      .frame_mark  (mark[g])
    );
    assign rx_sys_clock_out[g]        = s.nco[g][NMSB];
    assign rx_sys_clock_oe_n[g]       = s.oe_n;
    assign rx_sys_frame_pulse_out[g]  = mark[g];
    assign rx_sys_frame_pulse_oe_n[g] = s.oe_n;
  end

  rx_cdc_fifo #(
    .WIDTH (rx_sys_port_pkg::MUX_WORD_W),
    .DEPTH (rx_sys_port_pkg::MUX_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (clk),
    .wr_rst   (rst),
    .wr_data  (wr_word),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .rd_clk   (rx_muxed_clock),
    .rd_rst   (rst),
    .rd_data  (rd_word),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready)
  );

  // Multiplexed lines run on the system's multiplexed clock
  rx_link_serializer u_mux_ser (
    .clk         (rx_muxed_clock),
    .rst         (rst),
    .tick        (1'b1),
    .frame_sync  (m.fp_s2),
    .e1_mode     (1'b1),
    .word        (rd_word.word),
    .word_valid  (fifo_rd_valid),
    .word_ready  (fifo_rd_ready),
    .payload_out (rx_muxed_payload_out),
    .sig_out     (rx_muxed_signaling_out),
    .frame_mark  ()
  );
endmodule : rx_sys_port
`default_nettype wire

// file: bench/rx_sys_port_props.sv
`timescale 1ns/1ns
`default_nettype none
module rx_sys_port_props (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire rx_sys_port_pkg::port_mode_t link_mode,
  input wire logic                        rx_shared_slave_clock_sel,
  input wire logic [1:0]                  rx_sys_clock_in,
  input wire logic [1:0]                  rx_sys_clock_out,
  input wire logic [1:0]                  rx_sys_clock_oe_n,
  input wire logic [1:0]                  rx_sys_payload_out,
  input wire logic [1:0]                  rx_sys_signaling_out,
  input wire logic                        rx_muxed_clock,
  input wire logic                        rx_muxed_payload_out,
  input wire logic                        rx_muxed_signaling_out
);
  logic [3:0] run_cnt;
  logic       run;
  logic       mst;
  logic       slv;

  // Settle time after reset release
  always_ff @(posedge clk or posedge rst)
    if (rst)
      run_cnt <= 4'h0;
    else if (!run)
      run_cnt <= run_cnt + 4'h1;
  assign run = run_cnt == 4'hF;
  assign mst = run && link_mode == rx_sys_port_pkg::MODE_MASTER;
  assign slv = run && link_mode == rx_sys_port_pkg::MODE_SLAVE;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_edge0;
    $past(rx_sys_clock_in[0], 3) && !$past(rx_sys_clock_in[0], 7);
  endsequence
  sequence s_edge1;
    $past(rx_sys_clock_in[1], 3) && !$past(rx_sys_clock_in[1], 7);
  endsequence
  sequence s_mst_held;
    mst [*2];
  endsequence

  property p_master_oe;
    s_mst_held |-> rx_sys_clock_oe_n == 2'h0;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("clock not driven");
  property p_master_data;
    mst && $changed(rx_sys_payload_out[0]) |->
      $past(rx_sys_clock_out[0]) && !$past(rx_sys_clock_out[0], 4);
  endproperty
  a_master_data: assert property (p_master_data) else $error("data off edge");
  property p_master_sig;
    mst && $changed(rx_sys_signaling_out[1]) |->
      $past(rx_sys_clock_out[1]) && !$past(rx_sys_clock_out[1], 4);
  endproperty
  a_master_sig: assert property (p_master_sig) else $error("sig off edge");
  property p_slave_own;
    slv && !rx_shared_slave_clock_sel && $changed(rx_sys_payload_out[1]) |-> s_edge1;
  endproperty
  a_slave_own: assert property (p_slave_own) else $error("data off own clock");
  property p_slave_shared;
    slv && rx_shared_slave_clock_sel && $changed(rx_sys_payload_out[1]) |-> s_edge0;
  endproperty
  a_slave_shared: assert property (p_slave_shared) else $error("data off shared");
  property p_slave_sig;
    slv && $changed(rx_sys_signaling_out[1]) |->
      if (rx_shared_slave_clock_sel) s_edge0 else s_edge1;
  endproperty
  a_slave_sig: assert property (p_slave_sig) else $error("sig off clock");
  property p_mux_data;
    run && $changed(rx_muxed_payload_out) |-> rx_muxed_clock;
  endproperty
  a_mux_data: assert property (p_mux_data) else $error("muxed data off edge");
  property p_mux_sig;
    run && $changed(rx_muxed_signaling_out) |-> rx_muxed_clock;
  endproperty
  a_mux_sig: assert property (p_mux_sig) else $error("muxed sig off edge");
endmodule : rx_sys_port_props

bind rx_sys_port rx_sys_port_props u_props (
  .clk(clk), .rst(rst), .link_mode(link_mode),
  .rx_shared_slave_clock_sel(rx_shared_slave_clock_sel),
  .rx_sys_clock_in(rx_sys_clock_in), .rx_sys_clock_out(rx_sys_clock_out),
  .rx_sys_clock_oe_n(rx_sys_clock_oe_n), .rx_sys_payload_out(rx_sys_payload_out),
  .rx_sys_signaling_out(rx_sys_signaling_out), .rx_muxed_clock(rx_muxed_clock),
  .rx_muxed_payload_out(rx_muxed_payload_out),
  .rx_muxed_signaling_out(rx_muxed_signaling_out)
);
`default_nettype wire

// file: bench/sys_backplane_model.sv
`timescale 1ns/1ns
`default_nettype none
module sys_backplane_model (
  input  wire logic       rst,
  output logic      [1:0] sys_clk,
  output logic      [1:0] sys_fp,
  output logic            mux_clk,
  output logic            mux_fp
);
  logic [9:0] mux_cnt;

  // Per-link 2.048 MHz clock and 256-bit frame pulse
  for (genvar i = 0; i < 2; i++)
  begin : g_link
    logic [7:0] cnt;
    initial
    begin
      sys_clk[i] = 1'b0;
      #(38 + 150 * i);
      forever #244 sys_clk[i] = ~sys_clk[i];
    end
    always @(posedge sys_clk[i] or posedge rst)
      if (rst)
        cnt <= 8'hF8;
      else
        cnt <= cnt + 8'h01;
    always @(negedge sys_clk[i] or posedge rst)
      if (rst)
        sys_fp[i] <= 1'b0;
      else
        sys_fp[i] <= cnt == 8'hFF;
  end

  // Multiplexed clock and frame pulse
  initial
  begin
    mux_clk = 1'b0;
    #2;
    forever #32 mux_clk = ~mux_clk;
  end
  always @(posedge mux_clk or posedge rst)
    if (rst)
      mux_cnt <= 10'h3FD;
    else
      mux_cnt <= mux_cnt + 10'h001;
  always @(negedge mux_clk or posedge rst)
    if (rst)
      mux_fp <= 1'b0;
    else
      mux_fp <= mux_cnt == 10'h3FF;
endmodule : sys_backplane_model
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam rx_sys_port_pkg::chan_word_t W0 = {8'hA5, 4'h9};
  localparam rx_sys_port_pkg::chan_word_t W1 = {8'h3C, 4'h6};
  logic                        clk, rst, sh_sel, m_ck, m_fp, m_pay, m_sig;
  rx_sys_port_pkg::port_mode_t mode;
  rx_sys_port_pkg::chan_pair_t word;
  logic [1:0]                  e1, valid, ready, ck, ck_out, ck_oe_n, fp, fp_out, fp_oe_n;
  logic [1:0]                  pay, sg, part_ck, part_fp;
  int                          bad_count, checks_done, cycles;

  assign ck = (ck_oe_n & part_ck) | (~ck_oe_n & ck_out);
  assign fp = (fp_oe_n & part_fp) | (~fp_oe_n & fp_out);

  rx_sys_port DUT (
    .clk(clk), .rst(rst), .link_mode(mode), .rx_shared_slave_clock_sel(sh_sel),
    .e1_mode(e1), .link_word(word), .link_word_valid(valid), .link_word_ready(ready),
    .rx_sys_clock_in(ck), .rx_sys_clock_out(ck_out), .rx_sys_clock_oe_n(ck_oe_n),
    .rx_sys_frame_pulse_in(fp), .rx_sys_frame_pulse_out(fp_out),
    .rx_sys_frame_pulse_oe_n(fp_oe_n), .rx_sys_payload_out(pay),
    .rx_sys_signaling_out(sg), .rx_muxed_clock(m_ck), .rx_muxed_frame_pulse(m_fp),
    .rx_muxed_payload_out(m_pay), .rx_muxed_signaling_out(m_sig)
  );
  sys_backplane_model u_sys (
    .rst(rst), .sys_clk(part_ck), .sys_fp(part_fp), .mux_clk(m_ck), .mux_fp(m_fp)
  );

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic start(input rx_sys_port_pkg::port_mode_t md, input logic sh,
                       input logic [1:0] e, input logic [1:0] v);
    @(posedge clk);
    #1;
    rst = 1'b1;
    mode = md;
    sh_sel = sh;
    e1 = e;
    valid = v;
    repeat (13) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask : start

  // One byte from frame bit 0 of link li
  task automatic grab(input int ci, input int pi, input bit mst, input int li,
                      output logic [7:0] p, output logic [7:0] s);
    do
    begin
      if (mst)
        @(negedge ck[ci]);
      else
        @(posedge ck[ci]);
    end
    while (fp[pi] !== 1'b1);
    for (int b = 0; b < 8; b++)
    begin
      if (!mst || b > 0)
        @(negedge ck[ci]);
      p = {p[6:0], pay[li]};
      s = {s[6:0], sg[li]};
    end
  endtask : grab

  task automatic test_slave(input logic sh);
    logic [7:0] p0, s0, p1, s1;
    start(rx_sys_port_pkg::MODE_SLAVE, sh, 2'b11, 2'b11);
    fork
      grab(0, 0, 1'b0, 0, p0, s0);
      grab(sh ? 0 : 1, 1, 1'b0, 1, p1, s1);
    join
    chk(p0, W0.payload, "slave data 1");
    chk(s0, {4'h0, W0.sig}, "slave sig 1");
    chk(p1, W1.payload, "slave data 2");
    chk(s1, {4'h0, W1.sig}, "slave sig 2");
    $display("slave test done, shared %0d", sh);
  endtask : test_slave

  task automatic test_master();
    logic [7:0] p, s;
    time        t0;
    start(rx_sys_port_pkg::MODE_MASTER, 1'b0, 2'b01, 2'b11);
    for (int i = 0; i < 2; i++)
    begin
      repeat (2) @(posedge ck[i]);
      t0 = $time;
      @(posedge ck[i]);
      chk(32'(($time - t0) / 10 - (i ? 64 : 48)) >> 1, 0, "clock period");
    end
    grab(0, 0, 1'b1, 0, p, s);
    chk(p, W0.payload, "master data");
    chk(s, {4'h0, W0.sig}, "master sig");
    $display("master test done");
  endtask : test_master

  task automatic test_muxed();
    logic [95:0] ps, ss;
    int          k;
    start(rx_sys_port_pkg::MODE_MUXED, 1'b0, 2'b11, 2'b11);
    chk(ready, 2'b01, "link one taken first");
    @(posedge clk);
    #1;
    chk(ready, 2'b10, "link two taken next");
    repeat (96)
    begin
      @(negedge m_ck);
      ps = {ps[94:0], m_pay};
      ss = {ss[94:0], m_sig};
    end
    k = 0;
    while (k < 64 && ps[95-k -: 32] !== {W0.payload, W1.payload, W0.payload, W1.payload})
      k++;
    chk(k < 64, 1, "muxed interleave");
    chk(ss[95-k -: 32], {4'h0, W0.sig, 4'h0, W1.sig, 4'h0, W0.sig, 4'h0, W1.sig},
        "muxed sig");
    chk(k < 8, 1, "link one first");
    $display("muxed test done");
  endtask : test_muxed

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    mode = rx_sys_port_pkg::MODE_SLAVE;
    sh_sel = 1'b0;
    e1 = 2'b11;
    valid = 2'b00;
    word = {W1, W0};
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    test_slave(1'b0);
    test_slave(1'b1);
    test_master();
    test_muxed();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
